// ==== acs_params.svh ====
// Constants of the conversion sequencer: mode codes, FIFO depth, thresholds and timing counts
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_MODE_SINGLE    2'h0
`define ACS_MODE_FIXED     2'h1
`define ACS_MODE_SWEEP     2'h2
`define ACS_MODE_REPEAT    2'h3
`define ACS_FIFO_DEPTH     8
`define ACS_THR_FULL       4'h8
`define ACS_THR_HALF       4'h4
`define ACS_SHORT_SCLK     6'h10
`define ACS_LONG_SCLK      6'h30
`define ACS_EXT_DIV_LAST   2'h3
`define ACS_CONV_CLK_14    5'h12
`define ACS_CONV_CLK_12    5'h0D
`define ACS_CLK_NS         50
`define ACS_SETTLE_NS      15
`define ACS_SETTLE_CYC     ((`ACS_SETTLE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_OSC_DIV        3
`endif

// ==== acs_pkg.sv ====
// Types shared by the conversion sequencer files
package acs_pkg;
   typedef enum {ST_PDOWN, ST_SAMPLE, ST_CONV, ST_SETTLE} acs_state_t;
   typedef logic [2:0] acs_chan_t;
   typedef logic [1:0] acs_mode_t;
endpackage

// ==== acs_fifo.sv ====
// Result FIFO with flush, oldest entry on the head
`timescale 1ns/1ps
module acs_fifo import acs_pkg::*; #(
   parameter int DW    = 14,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   input  wire logic          push_i,
   input  wire logic [DW-1:0] data_i,
   input  wire logic          pop_i,
   input  wire logic          flush_i,
   output logic      [DW-1:0] head_o,
   output logic      [AW:0]   count_o
);
   logic [DW-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] wr_next;
   logic [AW-1:0] rd_reg;
   logic [AW-1:0] rd_next;
   logic [AW:0]   cnt_next;
   logic          do_push;
   logic          do_pop;

   //----------------------------------------------------------------------
   // Pointer logic
   //----------------------------------------------------------------------
   // Full FIFO refuses pushes so no stored result is lost silently
   always_comb begin
      // Depth cast to the count width: a pointer-width cast would read 8 as 0
      do_push  = push_i && (count_o != (AW+1)'(DEPTH)) && !flush_i;
      do_pop   = pop_i && (count_o != '0) && !flush_i;
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      cnt_next = count_o;
      if (flush_i) begin
         wr_next  = '0;
         rd_next  = '0;
         cnt_next = '0;
      end else begin
         if (do_push) begin
            wr_next = wr_reg + 1'b1;
         end
         if (do_pop) begin
            rd_next = rd_reg + 1'b1;
         end
         cnt_next = count_o + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         count_o <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         count_o <= cnt_next;
      end
   end

   // Storage, not reset: count alone says what is valid
   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem[wr_reg] <= data_i;
      end
   end

   assign head_o = mem[rd_reg];
endmodule

// ==== acs_sequencer.sv ====
// Conversion sequencer: clocking, sampling, conversion, FIFO and power-down
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_sequencer import acs_pkg::*; #(
   parameter int DW    = 14,
   parameter bit RES14 = 1'b1,
   parameter int DEPTH = `ACS_FIFO_DEPTH
) (
   input  wire logic               mclk_i,
   input  wire logic               nrst_i,
   input  wire logic               sclk_i,
   input  wire logic               chip_select_n_i,
   input  wire logic               frame_sync_i,
   input  wire logic               conversion_start_n_i,
   input  wire logic               config_write_command_i,
   input  wire logic [1:0]         cfg_mode_i,
   input  wire logic               cfg_ext_clk_i,
   input  wire logic               cfg_long_sample_i,
   input  wire logic               cfg_thr_full_i,
   input  wire logic [2:0]         cfg_channel_i,
   input  wire logic [7:0][2:0]    cfg_sweep_seq_i,
   input  wire logic [DW-1:0]      adc_code_i,
   input  wire logic               fifo_pop_i,
   input  wire logic               fifo_read_end_i,
   output logic                    sampling_o,
   output logic                    powered_down_o,
   output logic                    conversion_done_o,
   output logic                    threshold_interrupt_n_o,
   output logic [2:0]              chan_sel_o,
   output logic [3:0]              fifo_level_o,
   output logic [DW-1:0]           rd_data_o
);
   localparam logic [4:0] CONV_CLKS = RES14 ? `ACS_CONV_CLK_14 : `ACS_CONV_CLK_12;
   localparam int         SETTLE    = (`ACS_SETTLE_CYC < 1) ? 1 : `ACS_SETTLE_CYC;

   acs_state_t    state_reg, state_next;
   acs_mode_t     mode_reg, mode_next;
   logic          ext_reg, ext_next, long_reg, long_next, full_reg, full_next;
   acs_chan_t     fix_reg, fix_next;
   logic [7:0][2:0] seq_reg, seq_next;
   logic [2:0]    ptr_reg, ptr_next;
   logic [5:0]    samp_reg, samp_next;
   logic [4:0]    conv_reg, conv_next;
   logic [1:0]    div_reg, div_next;
   logic [3:0]    set_reg, set_next;
   logic [1:0]    osc_reg, osc_next;
   logic          sclk_q, cs_q, fs_q, cst_q;
   logic          sclk_rise, trig, osc_tick, conv_tick;
   logic          push, flush, done_next, int_n_next;
   logic [2:0]    chan_next;
   logic [DW-1:0] rd_next;
   logic [DW-1:0] head;
   logic [3:0]    level;
   logic [3:0]    thr;
   logic [5:0]    samp_len;

   //----------------------------------------------------------------------
   // Next-state logic
   //----------------------------------------------------------------------
   // Pins are synchronous to mclk, so edges come from a single delay stage
   always_comb begin
      sclk_rise  = sclk_i && !sclk_q;
      trig       = (!chip_select_n_i && cs_q) || (frame_sync_i && !fs_q)
                   || (!conversion_start_n_i && cst_q);
      osc_next   = (osc_reg == 2'(`ACS_OSC_DIV - 1)) ? 2'h0 : osc_reg + 2'h1;
      osc_tick   = (osc_reg == 2'h0);
      conv_tick  = ext_reg ? (sclk_rise && div_reg == `ACS_EXT_DIV_LAST) : osc_tick;
      thr        = full_reg ? `ACS_THR_FULL : `ACS_THR_HALF;
      samp_len   = long_reg ? `ACS_LONG_SCLK : `ACS_SHORT_SCLK;
      state_next = state_reg;
      mode_next  = mode_reg;
      ext_next   = ext_reg;
      long_next  = long_reg;
      full_next  = full_reg;
      fix_next   = fix_reg;
      seq_next   = seq_reg;
      ptr_next   = ptr_reg;
      samp_next  = samp_reg;
      conv_next  = conv_reg;
      div_next   = div_reg;
      set_next   = set_reg;
      chan_next  = chan_sel_o;
      rd_next    = rd_data_o;
      push       = 1'b0;
      flush      = fifo_read_end_i;
      done_next  = 1'b0;
      case (state_reg)
         ST_PDOWN: begin
            // Config only taken while idle; nothing else changes it
            if (config_write_command_i) begin
               mode_next = cfg_mode_i;
               ext_next  = cfg_ext_clk_i;
               long_next = cfg_long_sample_i;
               full_next = cfg_thr_full_i;
               fix_next  = cfg_channel_i;
               seq_next  = cfg_sweep_seq_i;
               ptr_next  = 3'h0;
               flush     = 1'b1;
            end else if (trig) begin
               state_next = ST_SAMPLE;
               samp_next  = 6'h00;
               chan_next  = (mode_reg[1]) ? seq_reg[ptr_reg] : fix_reg;
               if (mode_reg[1] && ptr_reg == 3'h0) begin
                  flush = 1'b1;
               end
            end
         end
         ST_SAMPLE: begin
            if (sclk_rise) begin
               samp_next = samp_reg + 6'h01;
               if (samp_reg + 6'h01 == samp_len) begin
                  state_next = ST_CONV;
                  conv_next  = 5'h00;
                  div_next   = 2'h0;
               end
            end
         end
         ST_CONV: begin
            if (ext_reg && sclk_rise) begin
               div_next = div_reg + 2'h1;
            end
            if (conv_tick) begin
               conv_next = conv_reg + 5'h01;
               if (conv_reg + 5'h01 == CONV_CLKS) begin
                  state_next = ST_SETTLE;
                  set_next   = 4'h0;
               end
            end
         end
         ST_SETTLE: begin
            set_next = set_reg + 4'h1;
            if (set_reg + 4'h1 == 4'(SETTLE)) begin
               state_next = ST_PDOWN;
               done_next  = 1'b1;
               if (mode_reg == `ACS_MODE_SINGLE) begin
                  rd_next = adc_code_i;
               end else begin
                  push = 1'b1;
               end
               // Sweep pointer rewinds once a sweep fills the threshold
               if (mode_reg[1]) begin
                  ptr_next = ({1'b0, ptr_reg} + 4'h1 == thr) ? 3'h0 : ptr_reg + 3'h1;
               end
            end
         end
         default: begin
            state_next = ST_PDOWN;
         end
      endcase
      // Pop on an empty FIFO leaves the last read value in place
      if (fifo_pop_i && mode_reg != `ACS_MODE_SINGLE && level != 4'h0) begin
         rd_next = head;
      end
      int_n_next = !(level >= thr);
   end

   //----------------------------------------------------------------------
   // Registers
   //----------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= ST_PDOWN;
         mode_reg <= `ACS_MODE_SINGLE;
         ext_reg <= 1'b0;
         long_reg <= 1'b0;
         full_reg <= 1'b0;
         fix_reg <= 3'h0;
         seq_reg <= '0;
         ptr_reg <= 3'h0;
         samp_reg <= 6'h00;
         conv_reg <= 5'h00;
         div_reg <= 2'h0;
         set_reg <= 4'h0;
         osc_reg <= 2'h0;
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         fs_q <= 1'b0;
         cst_q <= 1'b1;
         sampling_o <= 1'b0;
         powered_down_o <= 1'b1;
         conversion_done_o <= 1'b0;
         threshold_interrupt_n_o <= 1'b1;
         chan_sel_o <= 3'h0;
         fifo_level_o <= 4'h0;
         rd_data_o <= '0;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         ext_reg <= ext_next;
         long_reg <= long_next;
         full_reg <= full_next;
         fix_reg <= fix_next;
         seq_reg <= seq_next;
         ptr_reg <= ptr_next;
         samp_reg <= samp_next;
         conv_reg <= conv_next;
         div_reg <= div_next;
         set_reg <= set_next;
         osc_reg <= osc_next;
         sclk_q <= sclk_i;
         cs_q <= chip_select_n_i;
         fs_q <= frame_sync_i;
         cst_q <= conversion_start_n_i;
         sampling_o <= (state_next == ST_SAMPLE);
         powered_down_o <= (state_next == ST_PDOWN);
         conversion_done_o <= done_next;
         threshold_interrupt_n_o <= int_n_next;
         chan_sel_o <= chan_next;
         fifo_level_o <= level;
         rd_data_o <= rd_next;
      end
   end

   // Result store; flush has priority and power-down never touches it
   acs_fifo #(.DW(DW), .DEPTH(DEPTH), .AW(3)) u_fifo (
      .clk_i   (mclk_i),
      .nrst_i  (nrst_i),
      .push_i  (push),
      .data_i  (adc_code_i),
      .pop_i   (fifo_pop_i),
      .flush_i (flush),
      .head_o  (head),
      .count_o (level)
   );

   //----------------------------------------------------------------------
   // Assertions
   //----------------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   property p_ext_tick;
      (state_reg == ST_CONV && ext_reg && conv_next != conv_reg) |-> sclk_rise && div_reg == 2'h3;
   endproperty
   a_ext_tick: assert property (p_ext_tick) else $error("external tick not on fourth sclk");

   property p_conv_len;
      (state_reg == ST_CONV && state_next == ST_SETTLE) |-> conv_tick && conv_reg == CONV_CLKS - 5'h01;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("wrong conversion clock count");

   property p_samp_len;
      $fell(sampling_o) |-> samp_reg == samp_len;
   endproperty
   a_samp_len: assert property (p_samp_len) else $error("wrong sampling length");

   property p_int_level;
      threshold_interrupt_n_o == !($past(level) >= $past(thr));
   endproperty
   a_int_level: assert property (p_int_level) else $error("interrupt disagrees with level");

   property p_cfg_flush;
      (state_reg == ST_PDOWN && config_write_command_i) |=> level == 4'h0 ##1 threshold_interrupt_n_o;
   endproperty
   a_cfg_flush: assert property (p_cfg_flush) else $error("config write left fifo data");

   property p_cfg_quiet;
      (state_reg == ST_PDOWN && config_write_command_i) |=> !conversion_done_o && powered_down_o;
   endproperty
   a_cfg_quiet: assert property (p_cfg_quiet) else $error("config write converted");

   property p_done_pd;
      conversion_done_o |-> powered_down_o && state_reg == ST_PDOWN;
   endproperty
   a_done_pd: assert property (p_done_pd) else $error("no power-down after conversion");

   property p_cfg_hold;
      (state_reg != ST_PDOWN) |=> $stable(mode_reg) && $stable(full_reg) && $stable(seq_reg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed outside write");

   property p_wake;
      (state_reg == ST_PDOWN && trig && !config_write_command_i) |=> sampling_o && !powered_down_o;
   endproperty
   a_wake: assert property (p_wake) else $error("trigger did not wake");

   c_done: cover property (conversion_done_o && mode_reg == `ACS_MODE_REPEAT);
   c_int: cover property ($fell(threshold_interrupt_n_o));
   c_ext: cover property (state_reg == ST_CONV && ext_reg && conv_tick);
endmodule

// ==== acs_host_model.sv ====
// Host model: serial master that makes the serial clock and the frame sync pulse
`timescale 1ns/1ps
module acs_host_model (
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   input  wire logic sclk_run_i,
   input  wire logic fs_req_i,
   output logic      sclk_o,
   output logic      frame_sync_o
);
   logic [5:0] ph_reg;
   logic [5:0] ph_next;
   logic       fs_reg;
   logic       fs_next;

   //----------------------------------------------------------------------
   // Serial clock
   //----------------------------------------------------------------------
   // Runs only within frames and always ends on a 16-bit boundary
   always_comb begin
      ph_next = (sclk_run_i || ph_reg != 6'h00) ? ph_reg + 6'h01 : 6'h00;
      fs_next = fs_req_i && !fs_reg;
   end

   // Phase and frame sync registers
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ph_reg <= 6'h00;
         fs_reg <= 1'b0;
      end else begin
         ph_reg <= ph_next;
         fs_reg <= fs_next;
      end
   end

   // Idle low, rising edge launches and falling edge samples
   assign sclk_o       = ph_reg[1];
   assign frame_sync_o = fs_reg;
endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the conversion sequencer
`timescale 1ns/1ps
module tb_top;
   import acs_pkg::*;
   logic             mclk_i, nrst_i, sclk, frame_sync, sclk_run, fs_req;
   logic             cs_n, conversion_start_n_n, cfg_wr, ext_clk, long_s, thr_full, pop, rd_end;
   logic [1:0]       mode;
   logic [2:0]       chan;
   logic [7:0][2:0]  seq;
   logic [13:0]      code;
   logic             sampling, pdown, done, int_n;
   logic [2:0]       chan_sel;
   logic [3:0]       level;
   logic [13:0]      rd_data;
   int               miscompares, n_checks, cyc;

   acs_sequencer i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk), .chip_select_n_i(cs_n),
      .frame_sync_i(frame_sync), .conversion_start_n_i(conversion_start_n_n), .config_write_command_i(cfg_wr),
      .cfg_mode_i(mode), .cfg_ext_clk_i(ext_clk), .cfg_long_sample_i(long_s), .cfg_thr_full_i(thr_full),
      .cfg_channel_i(chan), .cfg_sweep_seq_i(seq), .adc_code_i(code), .fifo_pop_i(pop),
      .fifo_read_end_i(rd_end), .sampling_o(sampling), .powered_down_o(pdown), .conversion_done_o(done),
      .threshold_interrupt_n_o(int_n), .chan_sel_o(chan_sel), .fifo_level_o(level), .rd_data_o(rd_data));
   acs_host_model i_host (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_run_i(sclk_run), .fs_req_i(fs_req),
      .sclk_o(sclk), .frame_sync_o(frame_sync));

   //----------------------------------------------------------------------
   // Clock and watchdog
   //----------------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   // Whole run is about 5600 cycles, the ceiling leaves wide margin
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   //----------------------------------------------------------------------
   // Shared tasks
   //----------------------------------------------------------------------
   task automatic tick(input int n = 1);
      repeat (n) @(posedge mclk_i);
      #5;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Configuration write, accepted only in power-down
   task automatic cfg(input logic [1:0] m, input logic e, input logic l, input logic f, input logic [2:0] c);
      mode = m; ext_clk = e; long_s = l; thr_full = f; chan = c;
      cfg_wr = 1'b1;
      tick();
      cfg_wr = 1'b0;
      tick(2);
      chk("cfg level", 16'h0000, level);
      chk("cfg done", 16'h0000, done);
      chk("cfg int_n", 16'h0001, int_n);
   endtask
   // One conversion: trigger kind 0 chip select, 1 frame sync, 2 conversion start
   task automatic convert(input int kind, input int s_exp, input int c_exp);
      int n_s, n_c, i;
      n_s = 0; n_c = 0;
      sclk_run = 1'b1;
      if (kind == 0) cs_n = 1'b0;
      if (kind == 1) fs_req = 1'b1;
      if (kind == 2) conversion_start_n_n = 1'b0;
      tick();
      cs_n = 1'b1; fs_req = 1'b0; conversion_start_n_n = 1'b1;
      for (i = 0; i < 2000 && done !== 1'b1; i++) begin
         if (sampling === 1'b1) n_s++;
         else if (n_s > 0) n_c++;
         tick();
      end
      sclk_run = 1'b0;
      chk("done seen", 16'h0001, done);
      chk("sample len", 16'h0001, 16'(n_s >= s_exp - 4 && n_s <= s_exp + 4));
      chk("conv len", 16'h0001, 16'(n_c >= c_exp - 8 && n_c <= c_exp + 8));
      chk("pdown after", 16'h0001, pdown);
   endtask
   // Pop one entry and compare it
   task automatic pop_chk(input logic [13:0] exp);
      pop = 1'b1;
      tick();
      pop = 1'b0;
      tick();
      chk("pop data", 16'(exp), 16'(rd_data));
   endtask

   //----------------------------------------------------------------------
   // Scenarios
   //----------------------------------------------------------------------
   // Fixed channel, all triggers, half threshold, retention in power-down
   task automatic t_fixed();
      cfg(2'h1, 1'b0, 1'b0, 1'b0, 3'h5);
      chan = 3'h7; // Port change after the write must not leak in
      for (int k = 0; k < 4; k++) begin
         code = 14'h0100 + 14'(k);
         convert(k % 3, 64, 56);
         chk("fixed chan", 16'h0005, chan_sel);
         tick(3);
         chk("fixed level", 16'(k + 1), level);
         chk("fixed int_n", 16'(k < 3), int_n);
      end
      tick(100);
      chk("retained level", 16'h0004, level);
      for (int k = 0; k < 4; k++) pop_chk(14'h0100 + 14'(k));
      tick(2);
      chk("drained int_n", 16'h0001, int_n);
   endtask
   // Sweep, partial read then read end
   task automatic t_sweep();
      seq = '0;
      seq[0] = 3'h1; seq[1] = 3'h3; seq[2] = 3'h5; seq[3] = 3'h6;
      cfg(2'h2, 1'b0, 1'b0, 1'b0, 3'h0);
      for (int k = 0; k < 4; k++) begin
         code = 14'h0200 + 14'(k);
         convert(2, 64, 56);
         chk("sweep chan", 16'(seq[k]), chan_sel);
      end
      tick(3);
      chk("sweep int_n", 16'h0000, int_n);
      pop_chk(14'h0200);
      pop_chk(14'h0201);
      rd_end = 1'b1;
      tick();
      rd_end = 1'b0;
      tick(2);
      chk("read end level", 16'h0000, level);
   endtask
   // Repeat sweep, full threshold, external clock, long sampling
   task automatic t_repeat();
      for (int k = 0; k < 8; k++) seq[k] = 3'(7 - k);
      cfg(2'h3, 1'b1, 1'b1, 1'b1, 3'h0);
      for (int k = 0; k < 8; k++) begin
         code = 14'h0300 + 14'(k);
         convert(0, 192, 290);
         chk("repeat chan", 16'(seq[k]), chan_sel);
      end
      tick(3);
      chk("full level", 16'h0008, level);
      chk("full int_n", 16'h0000, int_n);
      code = 14'h0399;
      convert(1, 192, 290);
      chk("restart chan", 16'(seq[0]), chan_sel);
      tick(3);
      chk("overwrite level", 16'h0001, level);
      pop_chk(14'h0399);
   endtask
   // Single conversion mode stores nothing in the FIFO
   task automatic t_single();
      cfg(2'h0, 1'b0, 1'b0, 1'b0, 3'h2);
      code = 14'h1ABC;
      convert(0, 64, 56);
      chk("single chan", 16'h0002, chan_sel);
      tick(3);
      chk("single level", 16'h0000, level);
      chk("single data", 16'h1ABC, 16'(rd_data));
   endtask

   //----------------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------------
   initial begin
      miscompares = 0; n_checks = 0; cyc = 0;
      nrst_i = 1'b0; sclk_run = 1'b0; fs_req = 1'b0; cs_n = 1'b1; conversion_start_n_n = 1'b1;
      cfg_wr = 1'b0; mode = 2'h0; ext_clk = 1'b0; long_s = 1'b0; thr_full = 1'b0;
      chan = 3'h0; seq = '0; code = 14'h0000; pop = 1'b0; rd_end = 1'b0;
      tick(20);
      nrst_i = 1'b1;
      tick();
      chk("reset pdown", 16'h0001, pdown);
      chk("reset int_n", 16'h0001, int_n);
      chk("reset level", 16'h0000, level);
      t_fixed();
      t_sweep();
      t_repeat();
      t_single();
      tally_and_finish();
   end
endmodule
